// ===== rtl/rsc_pkg.sv
package rsc_pkg;
   // reset source codes
   typedef enum logic [2:0]
   {
      RSC_SRC_NONE = 3'h0,
      RSC_SRC_POR = 3'h1,
      RSC_SRC_LVR = 3'h2,
      RSC_SRC_WDT = 3'h3
   } rsc_src_t;

   // sequencer states
   typedef enum logic [1:0]
   {
      RSC_ST_IDLE = 2'h0,
      RSC_ST_APPLY = 2'h1,
      RSC_ST_DONE = 2'h2
   } rsc_state_t;

   localparam logic [7:0] RSC_RCTL_INIT = 8'h55;
   localparam logic [7:0] RSC_VCTL_INIT = 8'h55;
   localparam logic [7:0] RSC_WCTL_INIT = 8'h53;
   localparam logic [7:0] RSC_PORT_INIT = 8'hFF;
   localparam logic [7:0] RSC_ZERO8 = 8'h00;
   localparam int RSC_PC_W = 13;
   localparam int RSC_SP_W = 4;
   localparam int RSC_WDT_W = 16;
   localparam int RSC_TB_W = 16;
   localparam int RSC_INT_W = 8;
   localparam int RSC_TMR_W = 4;
endpackage

// ===== rtl/rsc_src_if.sv
`timescale 1ns/100ps
// decoded reset event passed from the capture stage to the loader
interface rsc_src_if;
   import rsc_pkg::*;
   logic valid;
   rsc_src_t src;
   logic low_power;
   modport capt (output valid, output src, output low_power);
   modport load (input valid, input src, input low_power);
endinterface

// ===== rtl/rsc_capture.sv
`timescale 1ns/100ps
// synchronises asynchronous reset-event pins and picks the winner
module rsc_capture
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // raw event pins
   input wire logic por_evt_i,
   input wire logic lvr_evt_i,
   input wire logic wdt_evt_i,
   input wire logic low_power_i,
   // decoded event
   rsc_src_if.capt ev
);
   logic [3:0] meta_r;
   logic [3:0] sync_r;
   logic [2:0] prev_r;

   // two-stage synchroniser; only sync_r is read by logic
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         meta_r <= 4'h0;
         sync_r <= 4'h0;
      end
      else
      begin
         meta_r <= {low_power_i, wdt_evt_i, lvr_evt_i, por_evt_i};
         sync_r <= meta_r;
      end
   end

   // rising-edge memory so one pulse gives one event
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         prev_r <= 3'h0;
      else
         prev_r <= sync_r[2:0];
   end

   // power-on outranks low voltage, which outranks watchdog
   always_comb
   begin
      ev.valid = |(sync_r[2:0] & ~prev_r);
      ev.low_power = sync_r[3];
      if (sync_r[0] && !prev_r[0])
         ev.src = RSC_SRC_POR;
      else if (sync_r[1] && !prev_r[1])
         ev.src = RSC_SRC_LVR;
      else if (sync_r[2] && !prev_r[2])
         ev.src = RSC_SRC_WDT;
      else
         ev.src = RSC_SRC_NONE;
   end
endmodule

// ===== rtl/rsc_reset_state.sv
`timescale 1ns/100ps
module rsc_reset_state
   import rsc_pkg::*;
#(
   parameter int PC_W = RSC_PC_W,
   parameter int SP_W = RSC_SP_W,
   parameter int WDT_W = RSC_WDT_W,
   parameter int TB_W = RSC_TB_W,
   parameter int INT_W = RSC_INT_W,
   parameter int TMR_W = RSC_TMR_W
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // reset event pins, asynchronous
   input wire logic por_evt_i,
   input wire logic lvr_evt_i,
   input wire logic wdt_evt_i,
   input wire logic low_power_i,
   // cpu power-down entry, same clock
   input wire logic sleep_enter_i,
   // reset status and state outputs
   output logic busy_o,
   output logic timeout_flag_o,
   output logic powerdown_flag_o,
   output logic [PC_W-1:0] pc_o,
   output logic [SP_W-1:0] sp_o,
   output logic [INT_W-1:0] int_en_o,
   output logic [TMR_W-1:0] tmr_on_o,
   output logic wdt_run_o,
   output logic [WDT_W-1:0] watchdog_counter_o,
   output logic [TB_W-1:0] timebase_o,
   output logic [7:0] reset_control_reg_o,
   output logic [7:0] low_voltage_control_reg_o,
   output logic [7:0] watchdog_control_reg_o,
   output logic [7:0] port_a_data_o,
   output logic [7:0] port_a_direction_o
);
   localparam logic [SP_W-1:0] SP_TOP = '0;

   rsc_src_if ev_if ();
   rsc_state_t state_r;
   rsc_src_t src_r;
   logic lp_r;
   logic is_por;
   logic is_lvr;
   logic is_wdt;
   logic full_load;

   // all checks run on the system clock and rest during reset
   default clocking cb_sys @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // true in the apply cycle of one reset kind; shared by three strobes
   function automatic logic apply_of(input rsc_state_t st,
      input rsc_src_t got, input rsc_src_t want);
      apply_of = (st == RSC_ST_APPLY) && (got == want);
   endfunction

   rsc_capture u_capt
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .por_evt_i(por_evt_i),
      .lvr_evt_i(lvr_evt_i),
      .wdt_evt_i(wdt_evt_i),
      .low_power_i(low_power_i),
      .ev(ev_if)
   );

   // latch the event; a new event is ignored while applying
   // an edge that lands while busy is lost, so events need 3 cycles apart
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= RSC_ST_IDLE;
         src_r <= RSC_SRC_NONE;
         lp_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            RSC_ST_IDLE:
            begin
               if (ev_if.valid)
               begin
                  state_r <= RSC_ST_APPLY;
                  src_r <= ev_if.src;
                  lp_r <= ev_if.low_power;
               end
            end
            RSC_ST_APPLY:
               state_r <= RSC_ST_DONE;
            RSC_ST_DONE:
               state_r <= RSC_ST_IDLE;
            default:
               state_r <= RSC_ST_IDLE;
         endcase
      end
   end

   // decoded apply strobes
   assign is_por = apply_of(state_r, src_r, RSC_SRC_POR);
   assign is_lvr = apply_of(state_r, src_r, RSC_SRC_LVR);
   assign is_wdt = apply_of(state_r, src_r, RSC_SRC_WDT);
   // a sleeping watchdog reset keeps almost everything
   assign full_load = is_por || is_lvr || (is_wdt && !lp_r);
   assign busy_o = (state_r != RSC_ST_IDLE);

   // status flags; reset event wins over power-down entry
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         timeout_flag_o <= 1'b0;
         powerdown_flag_o <= 1'b0;
      end
      else if (is_por)
      begin
         timeout_flag_o <= 1'b0;
         powerdown_flag_o <= 1'b0;
      end
      else if (is_wdt)
      begin
         timeout_flag_o <= 1'b1;
         if (lp_r)
            powerdown_flag_o <= 1'b1;
      end
      else if (is_lvr)
      begin
         // flags keep their value here
         timeout_flag_o <= timeout_flag_o;
      end
      else if (sleep_enter_i)
         powerdown_flag_o <= 1'b1;
   end

   // pc and sp cleared on every reset kind
   // the stack top is encoded as zero, so both clear to the same value
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pc_o <= '0;
         sp_o <= SP_TOP;
      end
      else if (is_por || is_lvr || is_wdt)
      begin
         pc_o <= '0;
         sp_o <= SP_TOP;
      end
   end

   // interrupts, timers, watchdog and time base
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         int_en_o <= '0;
         tmr_on_o <= '0;
         wdt_run_o <= 1'b0;
         watchdog_counter_o <= '0;
         timebase_o <= '0;
      end
      else if (full_load)
      begin
         int_en_o <= '0;
         tmr_on_o <= '0;
         wdt_run_o <= 1'b1;
         watchdog_counter_o <= '0;
         timebase_o <= '0;
      end
      else if (wdt_run_o)
      begin
         // free-running; overflow detection lives elsewhere
         watchdog_counter_o <= watchdog_counter_o + WDT_W'(1);
         timebase_o <= timebase_o + TB_W'(1);
      end
   end

   // control and port registers with their init values
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         reset_control_reg_o <= RSC_RCTL_INIT;
         low_voltage_control_reg_o <= RSC_VCTL_INIT;
         watchdog_control_reg_o <= RSC_WCTL_INIT;
         port_a_data_o <= RSC_PORT_INIT;
         port_a_direction_o <= RSC_PORT_INIT;
      end
      else if (full_load)
      begin
         reset_control_reg_o <= RSC_RCTL_INIT;
         low_voltage_control_reg_o <= RSC_VCTL_INIT;
         watchdog_control_reg_o <= RSC_WCTL_INIT;
         port_a_data_o <= RSC_PORT_INIT;
         port_a_direction_o <= RSC_PORT_INIT;
      end
   end

   // checks
   sequence s_wdt_sleep;
      is_wdt && lp_r;
   endsequence

   sequence s_wdt_fast;
      is_wdt && !lp_r;
   endsequence

   // an event taken while the sequencer is idle
   sequence s_accept;
      state_r == RSC_ST_IDLE && ev_if.valid;
   endsequence

   // busy through apply and done, then idle again
   sequence s_busy_pair;
      busy_o [*2] ##1 !busy_o;
   endsequence

   a_sleep_wdt_flags: assert property
      (s_wdt_sleep |=> timeout_flag_o && powerdown_flag_o)
      else $error("sleep watchdog flags wrong");
   a_sleep_wdt_keep: assert property
      (s_wdt_sleep |=> $stable(port_a_data_o) && pc_o == '0)
      else $error("sleep watchdog changed state");
   a_sleep_wdt_run: assert property
      (s_wdt_sleep |=> $stable(wdt_run_o) && $stable(int_en_o)
         && $stable(tmr_on_o))
      else $error("sleep watchdog changed enables");
   a_sleep_wdt_regs: assert property
      (s_wdt_sleep |=> $stable(watchdog_control_reg_o)
         && $stable(reset_control_reg_o))
      else $error("sleep watchdog reloaded registers");
   a_por_flags_clear: assert property
      (is_por |=> !timeout_flag_o && !powerdown_flag_o)
      else $error("por flags not cleared");
   a_lvr_flags_keep: assert property
      (is_lvr |=> $stable(timeout_flag_o) && $stable(powerdown_flag_o))
      else $error("low voltage changed flags");
   a_fast_wdt_flags: assert property
      (s_wdt_fast |=> timeout_flag_o && $stable(powerdown_flag_o))
      else $error("fast watchdog flags wrong");
   a_fast_wdt_load: assert property
      (s_wdt_fast |=> wdt_run_o && int_en_o == '0
         && port_a_data_o == RSC_PORT_INIT)
      else $error("fast watchdog did not reload");
   a_lvr_load: assert property
      (is_lvr |=> wdt_run_o && tmr_on_o == '0 && int_en_o == '0)
      else $error("low voltage did not reload");
   a_por_int_off: assert property
      (is_por |=> int_en_o == '0 && tmr_on_o == '0)
      else $error("por left interrupts or timers on");
   a_por_wdt_clear: assert property
      (is_por |=> watchdog_counter_o == '0 && timebase_o == '0)
      else $error("watchdog or time base not cleared");
   a_wdt_starts: assert property
      (is_por |=> wdt_run_o ##1 watchdog_counter_o == WDT_W'(1))
      else $error("watchdog did not start");
   a_wdt_counts: assert property
      (wdt_run_o && !full_load |=>
         watchdog_counter_o == $past(watchdog_counter_o) + WDT_W'(1))
      else $error("watchdog stopped counting");
   a_init_values: assert property
      (full_load |=> watchdog_control_reg_o == RSC_WCTL_INIT
         && port_a_direction_o == RSC_PORT_INIT)
      else $error("init values not loaded");
   a_por_regs_init: assert property
      (is_por |=> reset_control_reg_o == RSC_RCTL_INIT
         && low_voltage_control_reg_o == RSC_VCTL_INIT
         && port_a_data_o == RSC_PORT_INIT)
      else $error("power-on left a register uninitialised");
   a_sp_top: assert property
      (is_por |=> sp_o == SP_TOP)
      else $error("stack pointer not at top");
   a_pc_cleared: assert property
      (is_por || is_lvr || is_wdt |=> pc_o == '0 && sp_o == SP_TOP)
      else $error("pc or sp not cleared");
   a_sleep_sets_pdf: assert property
      (sleep_enter_i && state_r == RSC_ST_IDLE |=> powerdown_flag_o)
      else $error("powerdown flag not set");
   a_busy_length: assert property
      (s_accept |=> s_busy_pair)
      else $error("busy did not last two cycles");
   a_event_latched: assert property
      (s_accept |=> src_r == $past(ev_if.src))
      else $error("reset source not latched");
endmodule

// ===== test/test_reset_state_control.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
   begin \
      comparisons++; \
      if ((got) !== (ex)) \
      begin \
         err_total++; \
         $display("unexpected %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module test_reset_state_control;
   import rsc_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic por_evt_i = 1'b0;
   logic lvr_evt_i = 1'b0;
   logic wdt_evt_i = 1'b0;
   logic low_power_i = 1'b0;
   logic sleep_enter_i = 1'b0;
   logic busy_o, timeout_flag_o, powerdown_flag_o, wdt_run_o;
   logic [RSC_PC_W-1:0] pc_o;
   logic [RSC_SP_W-1:0] sp_o;
   logic [RSC_INT_W-1:0] int_en_o;
   logic [RSC_TMR_W-1:0] tmr_on_o;
   logic [RSC_WDT_W-1:0] watchdog_counter_o;
   logic [RSC_TB_W-1:0] timebase_o;
   logic [7:0] reset_control_reg_o, low_voltage_control_reg_o;
   logic [7:0] watchdog_control_reg_o, port_a_data_o, port_a_direction_o;
   int err_total = 0;
   int comparisons = 0;
   // model flags
   logic m_to = 1'b0;
   logic m_pd = 1'b0;
   logic [2:0] tbl [6] = '{3'h4, 3'h0, 3'h4, 3'h2, 3'h1, 3'h6};
   logic tlp [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

   // 50 MHz clock
   always #10 clk_i = ~clk_i;

   rsc_reset_state dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .por_evt_i(por_evt_i), .lvr_evt_i(lvr_evt_i), .wdt_evt_i(wdt_evt_i),
      .low_power_i(low_power_i), .sleep_enter_i(sleep_enter_i),
      .busy_o(busy_o), .timeout_flag_o(timeout_flag_o),
      .powerdown_flag_o(powerdown_flag_o), .pc_o(pc_o), .sp_o(sp_o),
      .int_en_o(int_en_o), .tmr_on_o(tmr_on_o), .wdt_run_o(wdt_run_o),
      .watchdog_counter_o(watchdog_counter_o), .timebase_o(timebase_o),
      .reset_control_reg_o(reset_control_reg_o),
      .low_voltage_control_reg_o(low_voltage_control_reg_o),
      .watchdog_control_reg_o(watchdog_control_reg_o),
      .port_a_data_o(port_a_data_o),
      .port_a_direction_o(port_a_direction_o));

   task automatic end_of_test();
      if (err_total == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // bounded wait on busy_o reaching a level, sampled mid-cycle
   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 12 && busy_o !== lvl; i++)
         @(negedge clk_i);
      if (busy_o !== lvl)
      begin
         err_total++;
         $display("unexpected busy wait expected %0h seen %0h", lvl, busy_o);
         end_of_test();
      end
   endtask

   // compare flags and state; full marks a complete register load
   task automatic check_state(input logic full);
      `CHK("timeout_flag", m_to, timeout_flag_o)
      `CHK("powerdown_flag", m_pd, powerdown_flag_o)
      `CHK("pc", {RSC_PC_W{1'b0}}, pc_o)
      `CHK("sp", {RSC_SP_W{1'b0}}, sp_o)
      `CHK("rctl", RSC_RCTL_INIT, reset_control_reg_o)
      `CHK("vctl", RSC_VCTL_INIT, low_voltage_control_reg_o)
      `CHK("wctl", RSC_WCTL_INIT, watchdog_control_reg_o)
      `CHK("port", RSC_PORT_INIT, port_a_data_o)
      `CHK("dir", RSC_PORT_INIT, port_a_direction_o)
      if (full)
      begin
         `CHK("int_en", {RSC_INT_W{1'b0}}, int_en_o)
         `CHK("tmr_on", {RSC_TMR_W{1'b0}}, tmr_on_o)
         `CHK("wdt_run", 1'b1, wdt_run_o)
         `CHK("wdt_fresh", 1'b1, watchdog_counter_o < 16'h0008)
         `CHK("tb_fresh", 1'b1, timebase_o < 16'h0008)
      end
   endtask

   // raise event pins (bit0 power-on, bit1 low-voltage, bit2 watchdog)
   task automatic fire(input logic [2:0] m, input logic lp);
      logic full;
      @(posedge clk_i);
      por_evt_i <= m[0];
      lvr_evt_i <= m[1];
      wdt_evt_i <= m[2];
      low_power_i <= lp;
      full = 1'b1;
      if (m[0])
      begin
         m_to = 1'b0;
         m_pd = 1'b0;
      end
      else if (m[2] && !m[1])
      begin
         m_to = 1'b1;
         if (lp)
         begin
            m_pd = 1'b1;
            full = 1'b0;
         end
      end
      wait_busy(1'b1);
      wait_busy(1'b0);
      check_state(full);
      @(posedge clk_i);
      {wdt_evt_i, lvr_evt_i, por_evt_i} <= 3'h0;
      repeat (4) @(posedge clk_i);
      low_power_i <= 1'b0;
   endtask

   // cpu enters sleep: powerdown flag must come up
   task automatic do_sleep();
      @(posedge clk_i);
      sleep_enter_i <= 1'b1;
      @(posedge clk_i);
      sleep_enter_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      m_pd = 1'b1;
      `CHK("sleep_pd", m_pd, powerdown_flag_o)
   endtask

   // synchronous reset clears flags and stops the watchdog
   task automatic do_reset();
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_i);
      m_to = 1'b0;
      m_pd = 1'b0;
      check_state(1'b0);
      `CHK("rst_run", 1'b0, wdt_run_o)
      `CHK("rst_busy", 1'b0, busy_o)
   endtask

   initial
   begin : main
      int n;
      int act;
      void'($urandom(32'h92DE));
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      // directed cases: fast and sleep watchdog, cpu sleep, low-voltage in low power, power-on, priority
      for (n = 0; n < 6; n++)
      begin
         if (tbl[n] == 3'h0)
            do_sleep();
         else
            fire(tbl[n], tlp[n]);
      end
      for (n = 0; n < 60; n++)
      begin
         act = $urandom % 7;
         if (act == 0)
            do_sleep();
         else if (act == 1)
            do_reset();
         else
            fire(3'(($urandom % 7) + 1), 1'($urandom % 2));
      end
      end_of_test();
   end
endmodule
